// *** nvm_mem.sv ***
// Simple one-write, one-read memory with registered read data.
// Assumes a single clock; the array itself has no reset.
`timescale 1ns/1ps

module nvm_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // Read port
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata_q
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[raddr];
        end
    end
endmodule : nvm_mem

// *** nvm_prog_port.sv ***
// Parallel programming port: command, address and data loading, flash and
// EEPROM page programming and reading, and fuse writes.
// Assumes all programmer pins are asynchronous to core_clk and held well
// beyond two clock periods around each strobe.
`timescale 1ns/1ps
`include "pp_params.svh"

module nvm_prog_port #(
    parameter int PAGE_BITS   = 4,
    parameter int FLASH_AW    = 10,
    parameter int EE_AW       = 8,
    parameter int PROG_CYCLES = `PP_PROG_CYCLES
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Programmer control pins
    input  wire logic       load_type_select_hi,
    input  wire logic       load_type_select_lo,
    input  wire logic       byte_select_hi,
    input  wire logic       byte_select_lo,
    input  wire logic       load_strobe,
    input  wire logic       page_latch_strobe,
    input  wire logic       wr_n,
    input  wire logic       oe_n,
    // Data bus pins
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    // Status and fuses
    output logic            ready_busy_flag,
    output logic      [7:0] fuse_lo,
    output logic      [7:0] fuse_hi,
    output logic      [7:0] fuse_ext
);
    import pp_pkg::*;

    localparam int PW = PAGE_BITS + 1;
    localparam logic [19:0] PROG_LAST = 20'(PROG_CYCLES - 1);

    // Pin synchroniser; stage 3 only feeds the edge detectors.
    logic [`PP_PIN_W-1:0] pin1_q, pin2_q, pin3_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin1_q <= `PP_PIN_RST;
            pin2_q <= `PP_PIN_RST;
            pin3_q <= `PP_PIN_RST;
        end else begin
            pin1_q <= {load_type_select_hi, load_type_select_lo, byte_select_hi,
                       byte_select_lo, load_strobe, page_latch_strobe, wr_n, oe_n,
                       data_in};
            pin2_q <= pin1_q;
            pin3_q <= pin2_q;
        end
    end

    logic [7:0] din;
    logic [1:0] lt, bs;
    logic       strobe_rise, latch_rise, wr_fall, oe_low;
    assign din         = pin2_q[`PP_PIN_DATA_MSB:`PP_PIN_DATA_LSB];
    assign lt          = {pin2_q[`PP_PIN_LT_HI], pin2_q[`PP_PIN_LT_LO]};
    assign bs          = {pin2_q[`PP_PIN_BS_HI], pin2_q[`PP_PIN_BS_LO]};
    assign strobe_rise = pin2_q[`PP_PIN_STROBE] & ~pin3_q[`PP_PIN_STROBE];
    assign latch_rise  = pin2_q[`PP_PIN_LATCH] & ~pin3_q[`PP_PIN_LATCH];
    assign wr_fall     = ~pin2_q[`PP_PIN_WR_N] & pin3_q[`PP_PIN_WR_N];
    assign oe_low      = ~pin2_q[`PP_PIN_OE_N];

    // Loaded values and programming state.
    logic [7:0]     cmd_q, cmd_d, dlo_q, dlo_d, dhi_q, dhi_d;
    logic [23:0]    addr_q, addr_d;
    logic [7:0]     flo_q, flo_d, fhi_q, fhi_d, fext_q, fext_d;
    logic [7:0]     dout_q, dout_d;
    logic           doe_q, doe_d, rdy_q, rdy_d;
    prog_state_t    st_q, st_d;
    prog_tgt_t      tgt_q, tgt_d;
    logic [PW-1:0]  cnt_q, cnt_d;
    logic [19:0]    tmr_q, tmr_d;
    logic           idle, rd_cmd;

    logic [15:0]          pbuf_rd, flash_rd;
    logic [7:0]           ee_rd;
    logic                 pbuf_we, flash_we, ee_we;
    logic [PAGE_BITS-1:0] wr_idx;

    assign idle   = (st_q == ST_IDLE);
    assign rd_cmd = (cmd_q == `PP_CMD_RD_FLASH) || (cmd_q == `PP_CMD_RD_EE);

    always_comb begin
        cmd_d  = cmd_q;
        addr_d = addr_q;
        dlo_d  = dlo_q;
        dhi_d  = dhi_q;
        if (strobe_rise && idle) begin
            unique case (lt)
                `PP_LT_ADDR: begin
                    if (bs == `PP_BS_LOW) begin
                        addr_d[7:0] = din;
                    end else if (bs == `PP_BS_HIGH) begin
                        addr_d[15:8] = din;
                    end else if (bs == `PP_BS_EXT) begin
                        addr_d[23:16] = din;
                    end
                end
                `PP_LT_DATA: begin
                    if (bs[0]) begin
                        dhi_d = din;
                    end else begin
                        dlo_d = din;
                    end
                end
                `PP_LT_CMD: begin
                    cmd_d = din;
                end
                default: begin
                end
            endcase
        end
    end

    // Page buffer latch from the loaded data bytes.
    assign pbuf_we = latch_rise && bs[0] && idle;

    // Programming sequencer: copy the page buffer for flash and EEPROM, then hold busy.
    always_comb begin
        st_d  = st_q;
        tgt_d = tgt_q;
        cnt_d = cnt_q;
        tmr_d = tmr_q;
        rdy_d = rdy_q;
        flo_d = flo_q;
        fhi_d = fhi_q;
        fext_d = fext_q;
        unique case (st_q)
            ST_IDLE: begin
                // A no-operation command leaves no write enabled.
                if (wr_fall) begin
                    cnt_d = '0;
                    tmr_d = '0;
                    if (cmd_q == `PP_CMD_WR_FLASH && bs == `PP_BS_LOW) begin
                        st_d  = ST_COPY;
                        tgt_d = TGT_FLASH;
                        rdy_d = 1'b0;
                    end else if (cmd_q == `PP_CMD_WR_EE && bs == `PP_BS_LOW) begin
                        st_d  = ST_COPY;
                        tgt_d = TGT_EE;
                        rdy_d = 1'b0;
                    end else if (cmd_q == `PP_CMD_WR_FUSE) begin
                        st_d  = ST_WAIT;
                        tgt_d = TGT_FUSE;
                        rdy_d = 1'b0;
                        // Stored as written: a 0 bit reads back programmed.
                        if (bs == `PP_BS_LOW) begin
                            flo_d = dlo_q;
                        end else if (bs == `PP_BS_HIGH) begin
                            fhi_d = dlo_q;
                        end else if (bs == `PP_BS_EXT) begin
                            fext_d = dlo_q;
                        end
                    end
                end
            end
            ST_COPY: begin
                cnt_d = cnt_q + PW'(1);
                if (cnt_q == PW'(1 << PAGE_BITS)) begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                tmr_d = tmr_q + 20'h1;
                if (tmr_q >= PROG_LAST) begin
                    st_d  = ST_IDLE;
                    rdy_d = 1'b1;
                end
            end
            default: begin
                st_d  = ST_IDLE;
                rdy_d = 1'b1;
            end
        endcase
    end

    // Buffer read runs one cycle ahead of the array write.
    assign wr_idx   = cnt_q[PAGE_BITS-1:0] - PAGE_BITS'(1);
    assign flash_we = (st_q == ST_COPY) && (cnt_q != '0) && (tgt_q == TGT_FLASH);
    assign ee_we    = (st_q == ST_COPY) && (cnt_q != '0) && (tgt_q == TGT_EE);

    // Read path; the bus is released whenever output enable is high.
    always_comb begin
        dout_d = 8'h00;
        doe_d  = 1'b0;
        if (oe_low && cmd_q == `PP_CMD_RD_FLASH) begin
            doe_d  = 1'b1;
            dout_d = bs[0] ? flash_rd[15:8] : flash_rd[7:0];
        end else if (oe_low && cmd_q == `PP_CMD_RD_EE && !bs[0]) begin
            doe_d  = 1'b1;
            dout_d = ee_rd;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_q  <= `PP_CMD_NOP;
            addr_q <= 24'h000000;
            dlo_q  <= 8'h00;
            dhi_q  <= 8'h00;
            st_q   <= ST_IDLE;
            tgt_q  <= TGT_FLASH;
            cnt_q  <= '0;
            tmr_q  <= 20'h00000;
            rdy_q  <= 1'b1;
            flo_q  <= `PP_FUSE_LO_RST;
            fhi_q  <= `PP_FUSE_HI_RST;
            fext_q <= `PP_FUSE_EXT_RST;
            dout_q <= 8'h00;
            doe_q  <= 1'b0;
        end else begin
            cmd_q  <= cmd_d;
            addr_q <= addr_d;
            dlo_q  <= dlo_d;
            dhi_q  <= dhi_d;
            st_q   <= st_d;
            tgt_q  <= tgt_d;
            cnt_q  <= cnt_d;
            tmr_q  <= tmr_d;
            rdy_q  <= rdy_d;
            flo_q  <= flo_d;
            fhi_q  <= fhi_d;
            fext_q <= fext_d;
            dout_q <= dout_d;
            doe_q  <= doe_d;
        end
    end

    assign data_out        = dout_q;
    assign data_oe         = doe_q;
    assign ready_busy_flag = rdy_q;
    assign fuse_lo         = flo_q;
    assign fuse_hi         = fhi_q;
    assign fuse_ext        = fext_q;

    nvm_mem #(.WIDTH(16), .DEPTH(1 << PAGE_BITS), .AW(PAGE_BITS)) u_pbuf (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .wr_en    (pbuf_we),
        .waddr    (addr_q[PAGE_BITS-1:0]),
        .wdata    ({dhi_q, dlo_q}),
        .raddr    (cnt_q[PAGE_BITS-1:0]),
        .rdata_q  (pbuf_rd)
    );

    nvm_mem #(.WIDTH(16), .DEPTH(1 << FLASH_AW), .AW(FLASH_AW)) u_flash (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .wr_en    (flash_we),
        .waddr    ({addr_q[FLASH_AW-1:PAGE_BITS], wr_idx}),
        .wdata    (pbuf_rd),
        .raddr    (addr_q[FLASH_AW-1:0]),
        .rdata_q  (flash_rd)
    );

    nvm_mem #(.WIDTH(8), .DEPTH(1 << EE_AW), .AW(EE_AW)) u_ee (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .wr_en    (ee_we),
        .waddr    ({addr_q[EE_AW-1:PAGE_BITS], wr_idx}),
        .wdata    (pbuf_rd[7:0]),
        .raddr    (addr_q[EE_AW-1:0]),
        .rdata_q  (ee_rd)
    );

    // Checks.
    sequence addr_load_s(logic [1:0] sel);
        strobe_rise && idle && lt == `PP_LT_ADDR && bs == sel;
    endsequence

    sequence page_go_s(logic [7:0] code);
        wr_fall && idle && cmd_q == code && bs == `PP_BS_LOW;
    endsequence

    addr_hi_load_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        addr_load_s(`PP_BS_HIGH) |=> addr_q[15:8] == $past(din) && $stable(addr_q[23:16]))
        else $error("address high byte not loaded");
    addr_ext_load_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        addr_load_s(`PP_BS_EXT) |=> addr_q[23:16] == $past(din) && $stable(addr_q[15:0]))
        else $error("address extended byte not loaded");
    cmd_load_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        strobe_rise && idle && lt == `PP_LT_CMD |=> cmd_q == $past(din))
        else $error("command not loaded");
    data_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !(strobe_rise && lt == `PP_LT_DATA) |=> $stable(dlo_q) && $stable(dhi_q))
        else $error("data bytes changed without a strobe");
    flash_prog_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        page_go_s(`PP_CMD_WR_FLASH) |=> !rdy_q && st_q == ST_COPY ##1 !rdy_q[*8])
        else $error("flash page program did not go busy");
    ee_prog_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        page_go_s(`PP_CMD_WR_EE) |=> !rdy_q && tgt_q == TGT_EE)
        else $error("EEPROM page program did not go busy");
    nop_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        idle && cmd_q == `PP_CMD_NOP |=> idle && rdy_q)
        else $error("no-operation started a write");
    fuse_lo_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_fall && idle && cmd_q == `PP_CMD_WR_FUSE && bs == `PP_BS_LOW
        |=> fuse_lo == $past(dlo_q) && !ready_busy_flag)
        else $error("low fuse not written");
    bus_release_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !oe_low || !rd_cmd |=> !data_oe)
        else $error("data bus driven outside a read");
    flash_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        oe_low && cmd_q == `PP_CMD_RD_FLASH |=> data_oe
        && data_out == ($past(bs[0]) ? $past(flash_rd[15:8]) : $past(flash_rd[7:0])))
        else $error("flash read byte wrong");
endmodule : nvm_prog_port

// *** parallel_nvm_programming_port_tb_top.sv ***
// Self-checking testbench of the parallel programming port.
// Assumes pp_pkg, pp_params.svh, nvm_mem, nvm_prog_port and pp_programmer are compiled.
`timescale 1ns/1ps
`include "pp_params.svh"

module parallel_nvm_programming_port_tb_top;
    import pp_pkg::*;
    logic        core_clk;
    logic        arst_n;
    logic        lt_hi, lt_lo, bs_hi, bs_lo, ld_stb, pl_stb, wr_n, oe_n;
    logic [7:0]  data_in, data_out, fuse_lo, fuse_hi, fuse_ext;
    logic        data_oe, ready_busy_flag;
    int          err_total = 0;
    int          checked = 0;
    logic [31:0] seed;
    logic [7:0]  exp_fuse [3];
    logic [15:0] words [3];
    logic [3:0]  idx [3] = '{4'h0, 4'h1, 4'hf};

    nvm_prog_port #(.PROG_CYCLES(20)) i_dut (
        .core_clk(core_clk), .arst_n(arst_n),
        .load_type_select_hi(lt_hi), .load_type_select_lo(lt_lo),
        .byte_select_hi(bs_hi), .byte_select_lo(bs_lo),
        .load_strobe(ld_stb), .page_latch_strobe(pl_stb), .wr_n(wr_n), .oe_n(oe_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .ready_busy_flag(ready_busy_flag),
        .fuse_lo(fuse_lo), .fuse_hi(fuse_hi), .fuse_ext(fuse_ext));

    pp_programmer i_prog (
        .core_clk(core_clk),
        .load_type_select_hi(lt_hi), .load_type_select_lo(lt_lo),
        .byte_select_hi(bs_hi), .byte_select_lo(bs_lo),
        .load_strobe(ld_stb), .page_latch_strobe(pl_stb), .wr_n(wr_n), .oe_n(oe_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .ready_busy_flag(ready_busy_flag));

    always #2.5 core_clk = ~core_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check8

    task automatic do_write(input logic [1:0] bs, input logic exp_busy);
        logic busy;
        logic ok;
        i_prog.write(bs, busy);
        check8({7'h0, busy}, {7'h0, exp_busy}, "busy after write pulse");
        i_prog.wait_ready(ok);
        if (!ok) begin
            err_total++;
            $display("[FAIL] %0t ready never returned", $time);
            print_verdict();
        end
    endtask : do_write

    task automatic read_chk(input logic b, input logic [7:0] exp, input string what);
        logic [7:0] d;
        logic       oe;
        logic       off;
        i_prog.read(b, d, oe, off);
        check8(d, exp, what);
        check8({7'h0, oe}, 8'h01, "bus driven during read");
        check8({7'h0, off}, 8'h00, "bus released after read");
    endtask : read_chk

    initial begin
        logic [7:0] hi, base;
        logic [7:0] d;
        logic       oe, off, busy, ok;
        core_clk = 1'b0;
        arst_n = 1'b0;
        seed = 32'h2984;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        check8(fuse_lo & fuse_hi & fuse_ext, `PP_FUSE_LO_RST, "fuse reset");
        check8({6'h0, data_oe, ready_busy_flag}, 8'h01, "ready and bus at reset");
        // Fuse bytes, one per byte select; random values with programmed and erased bits.
        for (int i = 0; i < 3; i++) exp_fuse[i] = 8'hff;
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            exp_fuse[i] = seed[7:0];
            i_prog.load(`PP_LT_CMD, 2'h0, `PP_CMD_WR_FUSE);
            i_prog.load(`PP_LT_DATA, 2'h0, seed[7:0]);
            do_write(2'(i), 1'b1);
            check8(fuse_lo, exp_fuse[0], "fuse low");
            check8(fuse_hi, exp_fuse[1], "fuse high");
            check8(fuse_ext, exp_fuse[2], "fuse extended");
        end
        // Select 11 writes no fuse, and a command strobed while busy is dropped.
        i_prog.write(2'h3, busy);
        i_prog.load(`PP_LT_CMD, 2'h0, `PP_CMD_RD_FLASH);
        i_prog.wait_ready(ok);
        i_prog.read(1'b0, d, oe, off);
        check8({5'h0, busy, oe, ~ok}, 8'h04, "command taken while busy");
        check8(fuse_hi, exp_fuse[1], "fuse high kept");
        check8(fuse_ext, exp_fuse[2], "fuse extended kept");
        // Flash page: first, second and last word of a random page.
        seed = xs(seed);
        hi = {6'h0, seed[9:8]};
        base = {seed[3:0], 4'h0};
        i_prog.load(`PP_LT_CMD, 2'h0, `PP_CMD_WR_FLASH);
        i_prog.load(`PP_LT_ADDR, `PP_BS_HIGH, hi);
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            words[k] = seed[23:8];
            i_prog.load(`PP_LT_ADDR, `PP_BS_LOW, base | {4'h0, idx[k]});
            i_prog.load(`PP_LT_DATA, 2'h0, words[k][7:0]);
            i_prog.load(`PP_LT_DATA, 2'h1, words[k][15:8]);
            i_prog.latch();
        end
        do_write(2'h0, 1'b1);
        do_write(2'h1, 1'b0);
        i_prog.load(`PP_LT_CMD, 2'h0, `PP_CMD_RD_FLASH);
        i_prog.load(`PP_LT_ADDR, `PP_BS_EXT, 8'h00);
        i_prog.load(`PP_LT_ADDR, `PP_BS_HIGH, hi);
        for (int k = 0; k < 3; k++) begin
            i_prog.load(`PP_LT_ADDR, `PP_BS_LOW, base | {4'h0, idx[k]});
            read_chk(1'b0, words[k][7:0], "flash low byte");
            read_chk(1'b1, words[k][15:8], "flash high byte");
        end
        // EEPROM page with a random base.
        seed = xs(seed);
        base = {seed[7:4], 4'h0};
        i_prog.load(`PP_LT_CMD, 2'h0, `PP_CMD_WR_EE);
        i_prog.load(`PP_LT_ADDR, `PP_BS_HIGH, 8'h00);
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            words[k] = {8'h00, seed[7:0]};
            i_prog.load(`PP_LT_ADDR, `PP_BS_LOW, base | {4'h0, idx[k]});
            i_prog.load(`PP_LT_DATA, 2'h0, seed[7:0]);
            i_prog.latch();
        end
        do_write(2'h0, 1'b1);
        i_prog.load(`PP_LT_CMD, 2'h0, `PP_CMD_RD_EE);
        i_prog.load(`PP_LT_ADDR, `PP_BS_HIGH, 8'h00);
        for (int k = 0; k < 3; k++) begin
            i_prog.load(`PP_LT_ADDR, `PP_BS_LOW, base | {4'h0, idx[k]});
            read_chk(1'b0, words[k][7:0], "eeprom byte");
        end
        i_prog.read(1'b1, d, oe, off);
        check8({6'h0, oe, off}, 8'h00, "eeprom read with select high");
        // No-operation: a write pulse starts nothing and the bus stays released.
        i_prog.load(`PP_LT_CMD, 2'h0, `PP_CMD_NOP);
        do_write(2'h0, 1'b0);
        i_prog.read(1'b0, d, oe, off);
        check8({6'h0, oe, off}, 8'h00, "bus driven without read");
        check8(fuse_lo, exp_fuse[0], "fuse low kept");
        // Reset applied while the port is idle returns the fuses to erased and the port to ready.
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        check8(fuse_lo & fuse_hi & fuse_ext, `PP_FUSE_LO_RST, "fuse after reset");
        check8({6'h0, data_oe, ready_busy_flag}, 8'h01, "ready after reset");
        print_verdict();
    end
endmodule : parallel_nvm_programming_port_tb_top

// *** pp_params.svh ***
// Constants of the parallel programming port: pin positions, command codes,
// reset values and timing. Included by the package, nvm_prog_port and the testbench.
`ifndef PP_PARAMS_SVH
`define PP_PARAMS_SVH

// Positions in the synchronised pin vector.
`define PP_PIN_DATA_LSB  0
`define PP_PIN_DATA_MSB  7
`define PP_PIN_OE_N      8
`define PP_PIN_WR_N      9
`define PP_PIN_LATCH     10
`define PP_PIN_STROBE    11
`define PP_PIN_BS_LO     12
`define PP_PIN_BS_HI     13
`define PP_PIN_LT_LO     14
`define PP_PIN_LT_HI     15
`define PP_PIN_W         16
// Write and output enable idle high.
`define PP_PIN_RST       16'h0300

// Load types and byte selects.
`define PP_LT_ADDR       2'h0
`define PP_LT_DATA       2'h1
`define PP_LT_CMD        2'h2
`define PP_BS_LOW        2'h0
`define PP_BS_HIGH       2'h1
`define PP_BS_EXT        2'h2

// Command codes.
`define PP_CMD_NOP       8'h00
`define PP_CMD_RD_FLASH  8'h02
`define PP_CMD_RD_EE     8'h03
`define PP_CMD_WR_FLASH  8'h10
`define PP_CMD_WR_EE     8'h11
`define PP_CMD_WR_FUSE   8'h40

// Fuse reset values, all bits erased.
`define PP_FUSE_LO_RST   8'hff
`define PP_FUSE_HI_RST   8'hff
`define PP_FUSE_EXT_RST  8'hff

// Write pulse to ready: least time 3.7 ms at a 5 ns clock, rounded up.
`define PP_CLK_NS        5
`define PP_T_PROG_NS     3700000
`define PP_PROG_CYCLES   ((`PP_T_PROG_NS + `PP_CLK_NS - 1) / `PP_CLK_NS)

`endif

// *** pp_pkg.sv ***
// Types shared by the programming port modules.
// Assumes pp_params.svh is on the include path.
`include "pp_params.svh"

package pp_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COPY = 2'b01,
        ST_WAIT = 2'b10
    } prog_state_t;

    typedef enum logic [1:0] {
        TGT_FLASH = 2'b00,
        TGT_EE    = 2'b01,
        TGT_FUSE  = 2'b10
    } prog_tgt_t;
endpackage : pp_pkg

// *** pp_programmer.sv ***
// Behavioural model of the external parallel programmer driving the port pins.
// Assumes a free-running core_clk; every pin change is made just after a rising edge.
`timescale 1ns/1ps

module pp_programmer (
    // Clock
    input  wire logic       core_clk,
    // Pins driven towards the device
    output logic            load_type_select_hi,
    output logic            load_type_select_lo,
    output logic            byte_select_hi,
    output logic            byte_select_lo,
    output logic            load_strobe,
    output logic            page_latch_strobe,
    output logic            wr_n,
    output logic            oe_n,
    output logic      [7:0] data_in,
    // Pins driven by the device
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    input  wire logic       ready_busy_flag
);
    logic [7:0] drv_q;
    logic       drv_en_q;

    // A released bus shows the inverse of the last driven byte, never a stale copy.
    assign data_in = data_oe ? data_out : (drv_en_q ? drv_q : ~drv_q);

    initial begin
        {load_type_select_hi, load_type_select_lo, byte_select_hi, byte_select_lo} = 4'h0;
        {load_strobe, page_latch_strobe} = 2'h0;
        {wr_n, oe_n} = 2'h3;
        drv_q = 8'h00;
        drv_en_q = 1'b1;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wait_cyc

    task automatic load(input logic [1:0] lt, input logic [1:0] bs, input logic [7:0] d);
        wait_cyc(1);
        {load_type_select_hi, load_type_select_lo} <= lt;
        {byte_select_hi, byte_select_lo} <= bs;
        drv_q <= d;
        wait_cyc(5);
        load_strobe <= 1'b1;
        wait_cyc(5);
        load_strobe <= 1'b0;
        wait_cyc(5);
    endtask : load

    task automatic latch();
        wait_cyc(1);
        byte_select_lo <= 1'b1;
        wait_cyc(5);
        page_latch_strobe <= 1'b1;
        wait_cyc(5);
        page_latch_strobe <= 1'b0;
        wait_cyc(5);
    endtask : latch

    task automatic write(input logic [1:0] bs, output logic busy);
        wait_cyc(1);
        {byte_select_hi, byte_select_lo} <= bs;
        wait_cyc(5);
        wr_n <= 1'b0;
        wait_cyc(5);
        busy = ~ready_busy_flag;
        wr_n <= 1'b1;
        wait_cyc(5);
        {byte_select_hi, byte_select_lo} <= 2'h0;
    endtask : write

    // Nothing further is started until the device reports ready again or 300 cycles pass.
    task automatic wait_ready(output logic ok);
        ok = 1'b0;
        for (int n = 0; n < 300 && !ok; n++) begin
            wait_cyc(1);
            ok = (ready_busy_flag === 1'b1);
        end
    endtask : wait_ready

    task automatic read(input logic b, output logic [7:0] d, output logic oe, output logic off);
        wait_cyc(1);
        drv_en_q <= 1'b0;
        {byte_select_hi, byte_select_lo} <= {1'b0, b};
        oe_n <= 1'b0;
        wait_cyc(8);
        d = data_out;
        oe = data_oe;
        oe_n <= 1'b1;
        wait_cyc(8);
        off = data_oe;
        drv_en_q <= 1'b1;
    endtask : read
endmodule : pp_programmer
